// ==== common/sleep_ctrl_pkg.sv ====
// Purpose: Shared constants and types for the sleep mode power controller
// Assumes: 250 MHz system clock
// Notes:   Register bit positions, counts and mode codes live here
package sleep_ctrl_pkg;

  // ===========================================================
  // Clock rate and counter widths
  localparam int unsigned CLK_KHZ = 250000;
  localparam int unsigned WAKE_W  = 25;
  typedef logic [WAKE_W-1:0] wake_cnt_t;

  // ===========================================================
  // Sleep control register layout
  localparam int unsigned SLEEP_ARM_BIT = 0;
  localparam int unsigned SLEEP_SEL_LO  = 1;
  localparam int unsigned SLEEP_SEL_HI  = 2;
  localparam logic [7:0]  SLEEP_CTL_RST = 8'h00;

  // Core control register layout
  localparam int unsigned MON_OFF_BIT    = 6;
  localparam int unsigned MON_UNLOCK_BIT = 5;
  localparam logic [7:0]  CORE_CTL_RST   = 8'h00;

  // ===========================================================
  // Sleep select encodings
  typedef enum logic [1:0] {
    SEL_IDLE  = 2'h0,
    SEL_NOISE = 2'h1,
    SEL_PDOWN = 2'h2,
    SEL_RSVD  = 2'h3
  } sleep_sel_e;

  // ===========================================================
  // Wake source vector positions
  localparam int unsigned SRC_EXT0   = 0;
  localparam int unsigned SRC_EXT1   = 1;
  localparam int unsigned SRC_PINCHG = 2;
  localparam int unsigned SRC_TWI    = 3;
  localparam int unsigned SRC_WDT    = 4;
  localparam int unsigned SRC_EEPROM = 5;
  localparam int unsigned SRC_CONV   = 6;
  localparam int unsigned SRC_OTHER  = 7;
  localparam int unsigned SRC_N      = 8;
  localparam int unsigned ASYNC_N    = 5;

  // ===========================================================
  // Cycle counts
  localparam logic [2:0] UNLOCK_WIN_CYC = 3'h4;
  localparam logic [2:0] OFF_DELAY_CYC  = 3'h3;
  localparam logic [2:0] OFF_HOLD_CYC   = 3'h3;
  localparam int unsigned IRQ_HALT_CYC  = 4;
  localparam int unsigned START_CK      = 6;
  localparam int unsigned RESET_CK      = 14;
  localparam int unsigned SLOW_START_MS = 64;
  localparam int unsigned SLOW_START_CYC = SLOW_START_MS * CLK_KHZ;
  localparam int unsigned FAST_START_CYC = 16;

endpackage : sleep_ctrl_pkg

// ==== common/wake_timer_if.sv ====
// Purpose: Carrier between the sleep controller and its wake timer
// Assumes: One system clock
// Notes:   start is a one-cycle pulse, done a one-cycle pulse
`timescale 1ns/1ps
`default_nettype none
interface wake_timer_if;
  import sleep_ctrl_pkg::*;
  logic      start;
  wake_cnt_t load;
  logic      done;
  modport timer (input start, input load, output done);
  modport ctrl  (output start, output load, input done);
endinterface : wake_timer_if
`default_nettype wire

// ==== verilog/wake_delay_timer.sv ====
// Purpose: Down-counter timing the wake-up latency
// Assumes: load is at least one
// Notes:   done pulses load cycles after the start pulse
`timescale 1ns/1ps
`default_nettype none
module wake_delay_timer (
  input  wire logic     sys_clk_in,
  input  wire logic     rst_b_in,
  wake_timer_if.timer   tmr
);
  import sleep_ctrl_pkg::*;

  wake_cnt_t cnt_r;
  logic      busy_r;
  logic      done_r;

  // ===========================================================
  // Count down, pulse done on the last count
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      cnt_r  <= '0;
      busy_r <= 1'b0;
      done_r <= 1'b0;
    end else begin
      done_r <= 1'b0;
      if (tmr.start) begin
        cnt_r  <= tmr.load;
        busy_r <= 1'b1;
      end else if (busy_r) begin
        if (cnt_r <= WAKE_W'(1)) begin
          busy_r <= 1'b0;
          done_r <= 1'b1;
        end
        cnt_r <= cnt_r - WAKE_W'(1);
      end
    end
  end

  assign tmr.done = done_r;

endmodule : wake_delay_timer
`default_nettype wire

// ==== verilog/sleep_mode_power_controller.sv ====
// Purpose: Sleep mode entry, clock gating, wake-up and monitor control
// Assumes: Core pulses halt_exec_in once per halt instruction
// Notes:   Wake requests are already qualified by interrupt enables
`timescale 1ns/1ps
`default_nettype none

// Function
// RULE1: Sleep happens only when arm bit is one and halt executes.
// RULE2: Select 00 idle stops core and program memory clocks only.
// RULE3: Select 01 also stops peripheral clock; converter clock runs.
// RULE4: Noise mode wakes on conversion, resets, watchdog, two-wire, memory, pins.
// RULE5: Select 10 power-down stops oscillator and every generated clock.
// RULE6: Power-down wakes on resets, watchdog, two-wire match, level ints, pins.
// RULE7: In deep modes external lines wake only when level sensed.
// RULE8: Interrupt wake holds core four cycles past start-up, then services.
// RULE9: Wake-up never disturbs working registers or static memory.
// RULE10: Reset during sleep wakes device and restarts at reset vector.
// RULE11: Level wake sources hold their level until service begins.
// RULE12: Idle or noise entry starts a conversion if converter enabled.
// RULE13: Power-down wake waits start-up set by clock source select.
// RULE14: Monitor off right after power-down entry, back on at wake.
// RULE15: With monitor off, wake delay equals reset time-out.
// RULE16: Core control bit 6 turns monitor off in power-down; resets zero.
// RULE17: Sleep-off bit is written only through the timed unlock sequence.
// RULE18: Configured monitor keeps watching during sleep unless switched off.
// RULE19: Unlock write then sleep-off write within four cycles.
// RULE20: Sleep-off active three cycles after set, clears after three more.
// RULE21: Select 11 reserved; arm bit 0, select bits 2:1, reset zero.
// RULE22: Halt with arm bit zero does nothing; execution continues.
module sleep_mode_power_controller #(
  parameter sleep_ctrl_pkg::wake_cnt_t SLOW_START =
    sleep_ctrl_pkg::WAKE_W'(sleep_ctrl_pkg::SLOW_START_CYC),
  parameter sleep_ctrl_pkg::wake_cnt_t FAST_START =
    sleep_ctrl_pkg::WAKE_W'(sleep_ctrl_pkg::FAST_START_CYC)
) (
  input  wire logic       sys_clk_in,
  input  wire logic       rst_b_in,
  input  wire logic       sleep_ctl_wr_in,
  input  wire logic [7:0] sleep_ctl_wdata_in,
  input  wire logic       core_ctl_wr_in,
  input  wire logic [7:0] core_ctl_wdata_in,
  input  wire logic       halt_exec_in,
  input  wire logic       ext_irq_zero_in,
  input  wire logic       ext_irq_one_in,
  input  wire logic [1:0] ext_irq_level_in,
  input  wire logic       pin_change_in,
  input  wire logic       twi_match_in,
  input  wire logic       wdt_irq_in,
  input  wire logic       eeprom_ready_in,
  input  wire logic       conv_done_in,
  input  wire logic       other_irq_in,
  input  wire logic       ext_rst_req_in,
  input  wire logic       wdt_rst_req_in,
  input  wire logic       bor_rst_req_in,
  input  wire logic       monitor_enable_cfg_in,
  input  wire logic [1:0] clock_source_select_in,
  input  wire logic       converter_enable_in,
  output var  logic [7:0] sleep_control_reg_out,
  output var  logic [7:0] core_control_reg_out,
  output var  logic       core_clock_en_out,
  output var  logic       program_memory_clock_en_out,
  output var  logic       peripheral_clock_en_out,
  output var  logic       converter_clock_en_out,
  output var  logic       oscillator_en_out,
  output var  logic       supply_monitor_en_out,
  output var  logic       conv_start_out,
  output var  logic       irq_service_out,
  output var  logic       reset_vector_out,
  output var  logic       resume_next_out,
  output var  logic       sleeping_out
);
  import sleep_ctrl_pkg::*;

  typedef enum logic [1:0] {ST_ACTIVE, ST_SLEEP, ST_WAKE} pm_state_e;

  // ===========================================================
  // Declarations
  pm_state_e            state_r;
  sleep_sel_e           mode_r;
  logic                 arm_r;
  sleep_sel_e           sel_r;
  logic [2:0]           unlock_cnt_r;
  logic [2:0]           off_dly_r;
  logic [2:0]           off_hold_r;
  logic                 off_active_r;
  logic                 mon_off_r;
  logic                 wake_rst_r;
  logic                 conv_start_r;
  logic                 irq_svc_r;
  logic                 rst_vec_r;
  logic                 resume_r;
  logic [ASYNC_N-1:0]   src_meta_r;
  logic [ASYNC_N-1:0]   src_sync_r;
  logic [2:0]           rst_meta_r;
  logic [2:0]           rst_sync_r;
  logic [SRC_N-1:0]     src_all;
  logic                 rst_req;
  logic                 halt_sleeps;
  wake_cnt_t            wake_load;

  wake_timer_if tmr_if ();

  // ===========================================================
  // Wake qualification per mode
  function automatic logic wake_ok(input sleep_sel_e       m,
                                   input logic [1:0]       lvl,
                                   input logic [SRC_N-1:0] s);
    logic ext_lvl;
    ext_lvl = (s[SRC_EXT0] & lvl[0]) | (s[SRC_EXT1] & lvl[1]); // see RULE7
    case (m)
      SEL_IDLE:  wake_ok = |s;
      SEL_NOISE: wake_ok = ext_lvl | s[SRC_PINCHG] | s[SRC_TWI] |
                           s[SRC_WDT] | s[SRC_EEPROM] |
                           s[SRC_CONV];                        // see RULE4
      SEL_PDOWN: wake_ok = ext_lvl | s[SRC_PINCHG] | s[SRC_TWI] |
                           s[SRC_WDT];                         // see RULE6
      default:   wake_ok = 1'b0;
    endcase
  endfunction : wake_ok

  // Reset time-out in cycles
  function automatic wake_cnt_t reset_timeout(input wake_cnt_t slow);
    reset_timeout = WAKE_W'(RESET_CK) + slow;
  endfunction : reset_timeout

  // ===========================================================
  // Pin-side inputs through two flip-flops
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      src_meta_r <= '0;
      src_sync_r <= '0;
      rst_meta_r <= '0;
      rst_sync_r <= '0;
    end else begin
      src_meta_r <= {wdt_irq_in, twi_match_in, pin_change_in,
                     ext_irq_one_in, ext_irq_zero_in};
      src_sync_r <= src_meta_r;
      rst_meta_r <= {bor_rst_req_in, wdt_rst_req_in, ext_rst_req_in};
      rst_sync_r <= rst_meta_r;
    end
  end

  // Gather wake sources; same-clock ones need no sync
  assign src_all = {other_irq_in, conv_done_in, eeprom_ready_in,
                    src_sync_r};
  assign rst_req = |rst_sync_r;

  // Halt only sleeps when armed with a valid select
  assign halt_sleeps = halt_exec_in & arm_r &
                       (sel_r != SEL_RSVD);                    // see RULE1

  // ===========================================================
  // Sleep control register: arm and select
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      arm_r <= SLEEP_CTL_RST[SLEEP_ARM_BIT];                   // see RULE21
      sel_r <= sleep_sel_e'(SLEEP_CTL_RST[SLEEP_SEL_HI:SLEEP_SEL_LO]);
    end else if (sleep_ctl_wr_in) begin
      arm_r <= sleep_ctl_wdata_in[SLEEP_ARM_BIT];
      sel_r <= sleep_sel_e'(
        sleep_ctl_wdata_in[SLEEP_SEL_HI:SLEEP_SEL_LO]);       // see RULE21
    end
  end

  // ===========================================================
  // Timed unlock window for the sleep-off bit
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      unlock_cnt_r <= '0;
    end else if (core_ctl_wr_in &&
                 core_ctl_wdata_in[MON_OFF_BIT] &&
                 core_ctl_wdata_in[MON_UNLOCK_BIT]) begin
      unlock_cnt_r <= UNLOCK_WIN_CYC;                          // see RULE19
    end else if (core_ctl_wr_in || unlock_cnt_r == 3'h1) begin
      unlock_cnt_r <= '0;
    end else if (unlock_cnt_r != 3'h0) begin
      unlock_cnt_r <= unlock_cnt_r - 3'h1;
    end
  end

  // Sleep-off activation delay, then self-clearing hold
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      off_dly_r    <= '0;
      off_hold_r   <= '0;
      off_active_r <= CORE_CTL_RST[MON_OFF_BIT];               // see RULE16
    end else begin
      if (core_ctl_wr_in && unlock_cnt_r != 3'h0 &&
          core_ctl_wdata_in[MON_OFF_BIT] &&
          !core_ctl_wdata_in[MON_UNLOCK_BIT]) begin
        off_dly_r <= OFF_DELAY_CYC;                            // see RULE17
      end else if (off_dly_r != 3'h0) begin
        off_dly_r <= off_dly_r - 3'h1;
      end
      if (off_dly_r == 3'h1) begin
        off_active_r <= 1'b1;                                  // see RULE20
        off_hold_r   <= OFF_HOLD_CYC;
      end else if (off_hold_r == 3'h1) begin
        off_active_r <= 1'b0;                                  // see RULE20
        off_hold_r   <= '0;
      end else if (off_hold_r != 3'h0) begin
        off_hold_r <= off_hold_r - 3'h1;
      end
    end
  end

  // ===========================================================
  // Wake delay selection
  always_comb begin
    if (rst_req) begin
      wake_load = reset_timeout(SLOW_START);                   // see RULE10
    end else if (mode_r != SEL_PDOWN) begin
      wake_load = WAKE_W'(IRQ_HALT_CYC);                       // see RULE8
    end else if (mon_off_r) begin
      wake_load = reset_timeout(SLOW_START) +
                  WAKE_W'(IRQ_HALT_CYC);                       // see RULE15
    end else begin
      wake_load = WAKE_W'(START_CK) + WAKE_W'(IRQ_HALT_CYC) +
                  (clock_source_select_in[1] ? SLOW_START
                                             : FAST_START);    // see RULE13
    end
  end

  assign tmr_if.start = (state_r == ST_SLEEP) &&
                        (rst_req ||
                         wake_ok(mode_r, ext_irq_level_in, src_all));
  assign tmr_if.load  = wake_load;

  // ===========================================================
  // Power state machine
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      state_r    <= ST_ACTIVE;
      mode_r     <= SEL_IDLE;
      mon_off_r  <= 1'b0;
      wake_rst_r <= 1'b0;
    end else begin
      case (state_r)
        ST_ACTIVE: begin
          if (halt_sleeps) begin
            state_r    <= ST_SLEEP;
            mode_r     <= sel_r;                               // see RULE1
            wake_rst_r <= 1'b0;
            mon_off_r  <= (sel_r == SEL_PDOWN) &&
                          off_active_r;                        // see RULE14
          end
        end
        ST_SLEEP: begin
          if (tmr_if.start) begin
            state_r    <= ST_WAKE;
            wake_rst_r <= rst_req;                             // see RULE10
            mon_off_r  <= 1'b0;                                // see RULE14
          end
        end
        ST_WAKE: begin
          if (rst_req) begin
            wake_rst_r <= 1'b1;
          end
          if (tmr_if.done) begin
            state_r <= ST_ACTIVE;
          end
        end
        default: state_r <= ST_ACTIVE;
      endcase
    end
  end

  // ===========================================================
  // One-cycle event pulses toward the core and converter
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      conv_start_r <= 1'b0;
      irq_svc_r    <= 1'b0;
      rst_vec_r    <= 1'b0;
      resume_r     <= 1'b0;
    end else begin
      conv_start_r <= halt_sleeps && converter_enable_in &&
                      (sel_r == SEL_IDLE ||
                       sel_r == SEL_NOISE);                    // see RULE12
      resume_r     <= (state_r == ST_ACTIVE) && halt_exec_in &&
                      !halt_sleeps;                            // see RULE22
      // Interrupt wake resumes in place; nothing is cleared
      irq_svc_r    <= (state_r == ST_WAKE) && tmr_if.done &&
                      !wake_rst_r && !rst_req;                 // see RULE9
      rst_vec_r    <= (state_r == ST_WAKE) && tmr_if.done &&
                      (wake_rst_r || rst_req);                 // see RULE10
    end
  end

  // ===========================================================
  // Clock domain enables per state and mode
  always_comb begin
    core_clock_en_out           = (state_r == ST_ACTIVE);      // see RULE2
    program_memory_clock_en_out = (state_r == ST_ACTIVE);
    peripheral_clock_en_out     = (state_r != ST_SLEEP) ||
                                  (mode_r == SEL_IDLE);        // see RULE3
    converter_clock_en_out      = (state_r != ST_SLEEP) ||
                                  (mode_r != SEL_PDOWN);       // see RULE3
    oscillator_en_out           = (state_r != ST_SLEEP) ||
                                  (mode_r != SEL_PDOWN);       // see RULE5
    supply_monitor_en_out       = monitor_enable_cfg_in &&
                                  !((state_r == ST_SLEEP) &&
                                    mon_off_r);                // see RULE18
  end

  // ===========================================================
  // Readback and status
  assign sleep_control_reg_out = {5'h00, sel_r, arm_r};
  assign core_control_reg_out  = {1'b0, off_active_r, 6'h00};
  assign conv_start_out        = conv_start_r;
  assign irq_service_out       = irq_svc_r;
  assign reset_vector_out      = rst_vec_r;
  assign resume_next_out       = resume_r;
  assign sleeping_out          = (state_r != ST_ACTIVE);

  // ===========================================================
  // Wake latency timer
  wake_delay_timer u_wake_timer (
    .sys_clk_in (sys_clk_in),
    .rst_b_in   (rst_b_in),
    .tmr        (tmr_if.timer)
  );

endmodule : sleep_mode_power_controller
`default_nettype wire

// ==== test/sleep_ctrl_sva.sv ====
// Purpose: Port assertions for the sleep controller
// Assumes: One clock, asynchronous active-low reset
// Notes:   Bound to every controller instance
`timescale 1ns/1ps
`default_nettype none
module sleep_ctrl_sva (
  input wire logic       sys_clk_in,
  input wire logic       rst_b_in,
  input wire logic       halt_exec_in,
  input wire logic       core_ctl_wr_in,
  input wire logic [7:0] core_ctl_wdata_in,
  input wire logic       converter_enable_in,
  input wire logic       monitor_enable_cfg_in,
  input wire logic [7:0] sleep_control_reg_out,
  input wire logic [7:0] core_control_reg_out,
  input wire logic       core_clock_en_out,
  input wire logic       program_memory_clock_en_out,
  input wire logic       peripheral_clock_en_out,
  input wire logic       converter_clock_en_out,
  input wire logic       oscillator_en_out,
  input wire logic       supply_monitor_en_out,
  input wire logic       conv_start_out,
  input wire logic       resume_next_out,
  input wire logic       sleeping_out
);
  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (!rst_b_in);
  // ====
  // Decoded halt and mode
  logic [1:0] sel;
  logic       go;
  logic       arm;
  assign sel = sleep_control_reg_out[2:1];
  assign arm = sleep_control_reg_out[0];
  assign go  = halt_exec_in && !sleeping_out;
  // ====
  // Entry and clock gating
  AST_ARMED_SLEEP: assert property (go && arm && sel != 2'h3 |=>
    sleeping_out && !core_clock_en_out && !program_memory_clock_en_out)
    else $error("armed halt did not sleep");
  AST_UNARMED_NOP: assert property (go && !arm |=>
    resume_next_out && !sleeping_out) else $error("unarmed halt slept");
  AST_RSVD_NOP: assert property (go && arm && sel == 2'h3 |=>
    resume_next_out && !sleeping_out) else $error("reserved mode slept");
  AST_IDLE_CLKS: assert property ($rose(sleeping_out) && sel == 2'h0 |->
    peripheral_clock_en_out && converter_clock_en_out && oscillator_en_out)
    else $error("idle gated wrong clocks");
  AST_NOISE_CLKS: assert property ($rose(sleeping_out) && sel == 2'h1 |->
    !peripheral_clock_en_out && converter_clock_en_out && oscillator_en_out)
    else $error("noise mode gated wrong clocks");
  AST_PDOWN_CLKS: assert property ($rose(sleeping_out) && sel == 2'h2 |->
    !peripheral_clock_en_out && !converter_clock_en_out && !oscillator_en_out)
    else $error("power-down left a clock on");
  AST_CONV_START: assert property (go && arm && !sel[1] &&
    converter_enable_in |=> conv_start_out) else $error("no conversion");
  AST_WAKE_CLKS: assert property ($fell(sleeping_out) |->
    core_clock_en_out && peripheral_clock_en_out && oscillator_en_out)
    else $error("clocks off after wake");
  // ====
  // Monitor control
  AST_OFF_HOLD: assert property ($rose(core_control_reg_out[6]) |->
    core_control_reg_out[6] [*3] ##1 !core_control_reg_out[6])
    else $error("sleep-off bit held wrong time");
  AST_UNLOCK_SEQ: assert property (core_ctl_wr_in &&
    core_ctl_wdata_in == 8'h60 ##1 core_ctl_wr_in && core_ctl_wdata_in ==
    8'h40 |-> ##[2:4] core_control_reg_out[6]) else $error("unlock ignored");
  AST_MON_AWAKE: assert property (!sleeping_out |->
    supply_monitor_en_out == monitor_enable_cfg_in)
    else $error("monitor off while awake");
  // Main scenarios
  cover property ($rose(sleeping_out) && sel == 2'h2);
  cover property (resume_next_out);
  cover property ($rose(core_control_reg_out[6]));
endmodule : sleep_ctrl_sva
bind sleep_mode_power_controller sleep_ctrl_sva chk_i (
  .sys_clk_in, .rst_b_in, .halt_exec_in, .core_ctl_wr_in, .core_ctl_wdata_in,
  .converter_enable_in, .monitor_enable_cfg_in, .sleep_control_reg_out,
  .core_control_reg_out, .core_clock_en_out, .program_memory_clock_en_out,
  .peripheral_clock_en_out, .converter_clock_en_out, .oscillator_en_out,
  .supply_monitor_en_out, .conv_start_out, .resume_next_out, .sleeping_out);
`default_nettype wire

// ==== test/core_partner.sv ====
// Purpose: Core and interrupt source model facing the controller
// Assumes: Requests arrive as one-cycle strobes from the bench
// Notes:   Wake requests stay high until served
`timescale 1ns/1ps
`default_nettype none
module core_partner (
  input  wire logic       sys_clk_in,
  input  wire logic       rst_b_in,
  input  wire logic       halt_req_in,
  input  wire logic [7:0] raise_in,
  input  wire logic       served_in,
  output var  logic       halt_out,
  output var  logic [7:0] src_out
);
  // Halt instruction, one pulse per request
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      halt_out <= 1'b0;
    end else begin
      halt_out <= halt_req_in;
    end
  end
  // Level requests held until the service routine starts
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      src_out <= 8'h00;
    end else begin
      src_out <= served_in ? 8'h00 : (src_out | raise_in);
    end
  end
endmodule : core_partner
`default_nettype wire

// ==== test/sleep_mode_power_controller_bench.sv ====
// Purpose: Self-checking bench for the sleep controller
// Assumes: Shortened start-up counts of 20 and 5 cycles
// Notes:   Outputs sampled 1 ns after the clock edge
`timescale 1ns/1ps
`default_nettype none
module sleep_mode_power_controller_bench;
  import sleep_ctrl_pkg::*;
  localparam wake_cnt_t SLOW = 25'h14;
  localparam wake_cnt_t FAST = 25'h5;
  logic       clk, rst_b, sw, cw, hreq, cfg, cen, ereq, halt, cke, pme, pce;
  logic       cce, ose, mon, cst, irq, rvec, rnext, slp;
  logic [7:0] sd, cd, raise, src, sreg, creg;
  logic [1:0] lvl, css;
  int         fails, total_checks;
  // ====
  // Design and partner
  sleep_mode_power_controller #(.SLOW_START(SLOW), .FAST_START(FAST)) dut (
    .sys_clk_in(clk), .rst_b_in(rst_b), .sleep_ctl_wr_in(sw),
    .sleep_ctl_wdata_in(sd), .core_ctl_wr_in(cw), .core_ctl_wdata_in(cd),
    .halt_exec_in(halt), .ext_irq_zero_in(src[SRC_EXT0]),
    .ext_irq_one_in(src[SRC_EXT1]), .ext_irq_level_in(lvl),
    .pin_change_in(src[SRC_PINCHG]), .twi_match_in(src[SRC_TWI]),
    .wdt_irq_in(src[SRC_WDT]), .eeprom_ready_in(src[SRC_EEPROM]),
    .conv_done_in(src[SRC_CONV]), .other_irq_in(src[SRC_OTHER]),
    .ext_rst_req_in(ereq), .wdt_rst_req_in(1'b0), .bor_rst_req_in(1'b0),
    .monitor_enable_cfg_in(cfg), .clock_source_select_in(css),
    .converter_enable_in(cen), .sleep_control_reg_out(sreg),
    .core_control_reg_out(creg), .core_clock_en_out(cke),
    .program_memory_clock_en_out(pme), .peripheral_clock_en_out(pce),
    .converter_clock_en_out(cce), .oscillator_en_out(ose),
    .supply_monitor_en_out(mon), .conv_start_out(cst),
    .irq_service_out(irq), .reset_vector_out(rvec),
    .resume_next_out(rnext), .sleeping_out(slp));
  core_partner model (.sys_clk_in(clk), .rst_b_in(rst_b), .halt_req_in(hreq),
    .raise_in(raise), .served_in(irq | rvec), .halt_out(halt),
    .src_out(src));
  // ====
  // Helpers
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : tally_and_finish
  task automatic chk(input string what, input logic [31:0] seen, exp);
    total_checks++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  function automatic logic hit(input int w);
    case (w)
      0: return irq === 1'b1;
      1: return rvec === 1'b1;
      2: return slp === 1'b1;
      default: return rnext === 1'b1;
    endcase
  endfunction : hit
  task automatic poll(input int w, input int lim, output int n);
    n = 0;
    do begin
      @(posedge clk);
      #1;
      n++;
    end while (n < lim && !hit(w));
  endtask : poll
  task automatic must(input int w, input int lim, output int n);
    poll(w, lim, n);
    if (!hit(w)) begin
      fails++;
      $display("wrong value wait %0d expected 1 seen 0", w);
      tally_and_finish();
    end
  endtask : must
  task automatic wr_sleep(input logic [7:0] d);
    @(posedge clk);
    sw <= 1'b1;
    sd <= d;
    @(posedge clk);
    sw <= 1'b0;
  endtask : wr_sleep
  task automatic pulse(input logic h, input logic [7:0] r);
    @(posedge clk);
    hreq  <= h;
    raise <= r;
    @(posedge clk);
    hreq  <= 1'b0;
    raise <= 8'h00;
  endtask : pulse
  // ====
  // Scenarios
  task automatic t_nop;
    int n;
    chk("sleep_reg", sreg, SLEEP_CTL_RST);
    chk("core_reg", creg, CORE_CTL_RST);
    wr_sleep(8'h04);
    pulse(1'b1, 8'h00);
    must(3, 8, n);
    chk("asleep", slp, 1'b0);
    wr_sleep(8'h07);
    pulse(1'b1, 8'h00);
    must(3, 8, n);
    chk("sleep_reg", sreg, 8'h07);
  endtask : t_nop
  task automatic t_wake(input logic [1:0] m, input int s, input logic lv,
                        input logic wakes);
    int n;
    @(posedge clk);
    lvl <= {lv, lv};
    css <= {lv, 1'b0};
    wr_sleep({5'h00, m, 1'b1});
    pulse(1'b1, 8'h00);
    must(2, 8, n);
    chk("periph_clk", pce, m == 2'h0);
    chk("osc", ose, m != 2'h2);
    chk("monitor", mon, 1'b1);
    pulse(1'b0, 8'h01 << s);
    poll(0, 50, n);
    chk("woke", hit(0), wakes);
    if (!wakes) begin
      pulse(1'b0, 8'h01 << SRC_WDT);
      must(0, 60, n);
    end else begin
      chk("latency", n >= (m == 2'h2 ? (lv ? SLOW : FAST) +
        START_CK + IRQ_HALT_CYC : IRQ_HALT_CYC), 1'b1);
    end
  endtask : t_wake
  task automatic t_rst_wake;
    int n;
    wr_sleep(8'h03);
    pulse(1'b1, 8'h00);
    must(2, 8, n);
    @(posedge clk);
    ereq <= 1'b1;
    must(1, 80, n);
    chk("service", irq, 1'b0);
    @(posedge clk);
    ereq <= 1'b0;
  endtask : t_rst_wake
  task automatic t_mon;
    int n;
    @(posedge clk);
    cw <= 1'b1;
    cd <= 8'h40;
    @(posedge clk);
    cw <= 1'b0;
    repeat (6) @(posedge clk);
    #1;
    chk("no_unlock", creg[6], 1'b0);
    wr_sleep(8'h05);
    @(posedge clk);
    cw <= 1'b1;
    cd <= 8'h60;
    @(posedge clk);
    cd <= 8'h40;
    @(posedge clk);
    cw <= 1'b0;
    repeat (2) @(posedge clk);
    hreq <= 1'b1;
    @(posedge clk);
    hreq <= 1'b0;
    must(2, 8, n);
    chk("monitor", mon, 1'b0);
    pulse(1'b0, 8'h01 << SRC_WDT);
    must(0, 120, n);
    chk("latency", n >= RESET_CK + SLOW + IRQ_HALT_CYC, 1'b1);
    chk("monitor", mon, 1'b1);
  endtask : t_mon
  // ====
  // Clock and main sequence
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  initial begin
    {rst_b, sw, cw, hreq, ereq, sd, cd, raise, lvl, css} = '0;
    {cfg, cen} = 2'h3;
    repeat (4) @(posedge clk);
    rst_b <= 1'b1;
    t_nop();
    t_wake(2'h0, SRC_CONV, 1'b0, 1'b1);
    t_wake(2'h0, SRC_EXT0, 1'b0, 1'b1);
    t_wake(2'h1, SRC_OTHER, 1'b0, 1'b0);
    t_wake(2'h1, SRC_EXT0, 1'b0, 1'b0);
    t_wake(2'h1, SRC_EXT1, 1'b1, 1'b1);
    t_wake(2'h1, SRC_EEPROM, 1'b0, 1'b1);
    t_wake(2'h1, SRC_CONV, 1'b0, 1'b1);
    t_wake(2'h2, SRC_CONV, 1'b0, 1'b0);
    t_wake(2'h2, SRC_EEPROM, 1'b0, 1'b0);
    t_wake(2'h2, SRC_TWI, 1'b0, 1'b1);
    t_wake(2'h2, SRC_PINCHG, 1'b0, 1'b1);
    t_wake(2'h2, SRC_EXT0, 1'b1, 1'b1);
    t_rst_wake();
    t_mon();
    tally_and_finish();
  end
endmodule : sleep_mode_power_controller_bench
`default_nettype wire
